/* File: flash_host_pkg.sv */
// Constants, types and timing for the parallel NOR flash host controller
package flash_host_pkg;

    // Flash bus widths and write-buffer depth
    localparam int FLASH_ADDR_W = 22;
    localparam int FLASH_DATA_W = 16;
    localparam int BUF_WORDS_MAX = 16;

    // Clock period in ps; strobe timing in ns as the minimums to honour
    localparam int CLK_PERIOD_PS = 5000;
    localparam int T_ADDR_SETUP_NS = 10;
    localparam int T_WE_LOW_NS = 40;
    localparam int T_WE_HIGH_NS = 30;
    localparam int T_FIRST_ACCESS_NS = 70;
    localparam int T_BUSY_VALID_NS = 100;

    // Least time rounds up to whole cycles, never below one
    function automatic int ns_to_cycles(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cycles

    localparam int SETUP_CYC = ns_to_cycles(T_ADDR_SETUP_NS);
    localparam int WE_LOW_CYC = ns_to_cycles(T_WE_LOW_NS);
    localparam int WE_HIGH_CYC = ns_to_cycles(T_WE_HIGH_NS);
    localparam int ACCESS_CYC = ns_to_cycles(T_FIRST_ACCESS_NS);
    localparam int BUSY_VALID_CYC = ns_to_cycles(T_BUSY_VALID_NS);

    // Command codes and unlock addresses placed on the flash bus
    localparam logic [15:0] CODE_UNLOCK1 = 16'h00AA;
    localparam logic [15:0] CODE_UNLOCK2 = 16'h0055;
    localparam logic [15:0] CODE_PROGRAM = 16'h00A0;
    localparam logic [15:0] CODE_ERASE_SETUP = 16'h0080;
    localparam logic [15:0] CODE_BLOCK_ERASE = 16'h0030;
    localparam logic [15:0] CODE_BUF_LOAD = 16'h0025;
    localparam logic [15:0] CODE_BUF_COMMIT = 16'h0029;
    localparam logic [15:0] CODE_ABORT_RESET = 16'h00F0;
    localparam logic [21:0] ADDR_UNLOCK1 = 22'h00_0555;
    localparam logic [21:0] ADDR_UNLOCK2 = 22'h00_02AA;

    // Register offsets on the AXI4-Lite slave
    localparam logic [7:0] CMD_OFF = 8'h00;
    localparam logic [7:0] ADDR_OFF = 8'h04;
    localparam logic [7:0] WDATA_OFF = 8'h08;
    localparam logic [7:0] COUNT_OFF = 8'h0C;
    localparam logic [7:0] STATUS_OFF = 8'h10;
    localparam logic [7:0] RDATA_OFF = 8'h14;
    localparam logic [7:0] WP_OFF = 8'h18;
    localparam logic [1:0] BUF_REGION = 2'h1;

    // Field positions
    localparam int CMD_GO_BIT = 8;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_ERR_BIT = 1;
    localparam int ST_PIN_BIT = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Operations selectable through the command register
    typedef enum logic [2:0] {
        OP_READ,
        OP_PROGRAM,
        OP_BUFFER,
        OP_ERASE,
        OP_ABORT_RESET
    } op_t;

    // Address and data of one flash bus cycle
    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] data;
    } bus_cycle_t;

    // All pins that the controller drives toward the flash
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic wp_n;
        logic [21:0] addr;
        logic [15:0] dq_out;
        logic dq_oe;
    } flash_out_t;

endpackage : flash_host_pkg

/* File: flash_host_ctrl.sv */
// AXI4-Lite controlled host sequencer driving a parallel x16 NOR flash
// Notes on behaviour
// - Host writes with write strobe under select
// - Host erases block before programming it; OP_PROGRAM and OP_BUFFER program without erasing first
// - Host holds write-protect steady during sequences
// - Buffer load is words plus five cycles
// - Abort sets flag; host issues abort reset
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int BUF_WORDS = BUF_WORDS_MAX
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output flash_out_t flash_o,
    input wire logic [15:0] dq_in,
    input wire logic busy_indicator_n
);

    if (BUF_WORDS < 1 || BUF_WORDS > BUF_WORDS_MAX) begin : g_bad_depth
        $error("BUF_WORDS must be 1 to 16");
    end

    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_READ, S_BUSY_WAIT} state_t;

    state_t state_reg;
    op_t op_reg;
    flash_out_t flash_reg;
    logic [15:0] cnt_reg;
    logic [4:0] idx_reg;
    logic [4:0] nwords_reg;
    logic [21:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [4:0] count_reg;
    logic wp_cfg_reg;
    logic err_reg;
    logic [15:0] rd_word_reg;
    logic [15:0] buf_mem [BUF_WORDS];
    logic aw_held_reg, w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_bus_reg;
    logic [3:0] wstrb_reg;
    logic do_write, start_req, start_ok, count_ok;
    op_t op_sel;
    logic [4:0] idx_sel, last_idx;
    logic [3:0] buf_sel;
    bus_cycle_t cyc;

    // Byte-enable merge for a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                         input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nv[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Index of the final flash bus cycle for an operation
    function automatic logic [4:0] last_of(input op_t op, input logic [4:0] n);
        unique case (op)
            OP_PROGRAM: return 5'h03;
            OP_ERASE: return 5'h05;
            OP_ABORT_RESET: return 5'h02;
            OP_BUFFER: return 5'(n + 5'h04);
            default: return 5'h00;
        endcase
    endfunction : last_of

    // Address and data of bus cycle idx of an operation
    function automatic bus_cycle_t step_cycle(input op_t op, input logic [4:0] idx,
                                              input logic [4:0] n, input logic [21:0] a,
                                              input logic [15:0] d, input logic [15:0] bw);
        bus_cycle_t c;
        logic [21:0] blk;
        blk = {a[21:15], 15'h0000};
        c = '{addr: ADDR_UNLOCK1, data: CODE_UNLOCK1};
        if (op == OP_READ) begin
            c = '{addr: a, data: 16'h0000};
        end else if (idx == 5'h01) begin
            c = '{addr: ADDR_UNLOCK2, data: CODE_UNLOCK2};
        end else if (idx >= 5'h02) begin
            unique case (op)
                OP_PROGRAM: c = (idx == 5'h02)
                                ? bus_cycle_t'{addr: ADDR_UNLOCK1, data: CODE_PROGRAM}
                                : bus_cycle_t'{addr: a, data: d};
                OP_ERASE: begin
                    if (idx == 5'h02) c = '{addr: ADDR_UNLOCK1, data: CODE_ERASE_SETUP};
                    else if (idx == 5'h04) c = '{addr: ADDR_UNLOCK2, data: CODE_UNLOCK2};
                    else if (idx == 5'h05) c = '{addr: blk, data: CODE_BLOCK_ERASE};
                end
                OP_ABORT_RESET: c = '{addr: ADDR_UNLOCK1, data: CODE_ABORT_RESET};
                OP_BUFFER: begin
                    if (idx == 5'h02) begin
                        c = '{addr: blk, data: CODE_BUF_LOAD};
                    end else if (idx == 5'h03) begin
                        c = '{addr: blk, data: {11'h000, 5'(n - 5'h01)}};
                    end else if (idx == 5'(n + 5'h04)) begin
                        c = '{addr: blk, data: CODE_BUF_COMMIT};
                    end else begin
                        c = '{addr: {a[21:4], 4'(idx - 5'h04)}, data: bw};
                    end
                end
                default: c = '{addr: a, data: d};
            endcase
        end
        return c;
    endfunction : step_cycle

    // AXI handshakes: one write and one read in flight at a time
    assign awready = !aw_held_reg;
    assign wready = !w_held_reg;
    assign arready = !rvalid;
    assign do_write = aw_held_reg && w_held_reg && !bvalid;
    assign start_req = do_write && awaddr_reg == CMD_OFF && wstrb_reg[1]
                       && wdata_bus_reg[CMD_GO_BIT];
    assign count_ok = count_reg >= 5'h01 && count_reg <= 5'(BUF_WORDS);
    assign start_ok = start_req && state_reg == S_IDLE
                      && (op_t'(wdata_bus_reg[2:0]) != OP_BUFFER || count_ok);

    // Write channel capture; address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_bus_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                w_held_reg <= 1'b1;
                wdata_bus_reg <= wdata;
                wstrb_reg <= wstrb;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (awaddr_reg[7:6] == BUF_REGION || awaddr_reg <= WP_OFF)
                         ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Software registers; status writes of one clear the error flag, a new error wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_reg <= 22'h00_0000;
            wdata_reg <= 16'h0000;
            count_reg <= 5'h01;
            wp_cfg_reg <= 1'b1;
            err_reg <= 1'b0;
        end else begin
            if (do_write) begin
                unique case (awaddr_reg)
                    ADDR_OFF: addr_reg <= 22'(merge(32'(addr_reg), wdata_bus_reg, wstrb_reg));
                    WDATA_OFF: wdata_reg <= 16'(merge(32'(wdata_reg), wdata_bus_reg, wstrb_reg));
                    COUNT_OFF: count_reg <= 5'(merge(32'(count_reg), wdata_bus_reg, wstrb_reg));
                    WP_OFF: wp_cfg_reg <= wstrb_reg[0] ? wdata_bus_reg[0] : wp_cfg_reg;
                    STATUS_OFF: begin
                        if (wstrb_reg[0] && wdata_bus_reg[ST_ERR_BIT]) err_reg <= 1'b0;
                    end
                    default: ;
                endcase
            end
            if (start_req && !start_ok) begin
                err_reg <= 1'b1;
            end
        end
    end

    // Buffer words; flip-flop storage keeps the sequencer free of memory latency
    always_ff @(posedge aclk) begin
        if (do_write && awaddr_reg[7:6] == BUF_REGION && 32'(awaddr_reg[5:2]) < BUF_WORDS) begin
            buf_mem[awaddr_reg[5:2]] <= 16'(merge(32'(buf_mem[awaddr_reg[5:2]]),
                                                  wdata_bus_reg, wstrb_reg));
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            unique case (araddr)
                CMD_OFF: rdata <= {29'h0000_0000, op_reg};
                ADDR_OFF: rdata <= {10'h000, addr_reg};
                WDATA_OFF: rdata <= {16'h0000, wdata_reg};
                COUNT_OFF: rdata <= {27'h000_0000, count_reg};
                STATUS_OFF: rdata <= {29'h0000_0000, busy_indicator_n, err_reg,
                                      state_reg != S_IDLE};
                RDATA_OFF: rdata <= {16'h0000, rd_word_reg};
                WP_OFF: rdata <= {31'h0000_0000, wp_cfg_reg};
                default: begin
                    if (araddr[7:6] == BUF_REGION && 32'(araddr[5:2]) < BUF_WORDS) begin
                        rdata <= {16'h0000, buf_mem[araddr[5:2]]};
                    end else begin
                        rdata <= 32'h0000_0000;
                        rresp <= RESP_SLVERR;
                    end
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // Next bus cycle: from the command at start, else the following index
    assign op_sel = (state_reg == S_IDLE) ? op_t'(wdata_bus_reg[2:0]) : op_reg;
    assign idx_sel = (state_reg == S_IDLE) ? 5'h00 : 5'(idx_reg + 5'h01);
    assign buf_sel = 4'(idx_sel - 5'h04);
    assign last_idx = last_of(op_reg, nwords_reg);
    assign cyc = step_cycle(op_sel, idx_sel, (state_reg == S_IDLE) ? count_reg : nwords_reg,
                            addr_reg, wdata_reg,
                            (32'(buf_sel) < BUF_WORDS) ? buf_mem[buf_sel] : 16'h0000);
    assign flash_o = flash_reg;

    // Flash sequencer; address and data are set a full setup time before the strobe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= S_IDLE;
            op_reg <= OP_READ;
            cnt_reg <= 16'h0000;
            idx_reg <= 5'h00;
            nwords_reg <= 5'h01;
            rd_word_reg <= 16'h0000;
            flash_reg <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, wp_n: 1'b1,
                           addr: 22'h00_0000, dq_out: 16'h0000, dq_oe: 1'b0};
        end else begin
            unique case (state_reg)
                S_IDLE: begin
                    // protect level changes only between sequences
                    flash_reg.wp_n <= wp_cfg_reg;
                    if (start_ok) begin
                        op_reg <= op_sel;
                        nwords_reg <= count_reg;
                        idx_reg <= 5'h00;
                        flash_reg.ce_n <= 1'b0;
                        flash_reg.addr <= cyc.addr;
                        flash_reg.dq_out <= cyc.data;
                        flash_reg.dq_oe <= op_sel != OP_READ;
                        cnt_reg <= 16'(SETUP_CYC - 1);
                        state_reg <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (cnt_reg != 16'h0000) begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end else if (op_reg == OP_READ) begin
                        flash_reg.oe_n <= 1'b0;
                        cnt_reg <= 16'(ACCESS_CYC - 1);
                        state_reg <= S_READ;
                    end else begin
                        // strobe falls with select held low
                        flash_reg.we_n <= 1'b0;
                        cnt_reg <= 16'(WE_LOW_CYC - 1);
                        state_reg <= S_STROBE;
                    end
                end
                S_STROBE: begin
                    if (cnt_reg != 16'h0000) begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end else begin
                        flash_reg.we_n <= 1'b1;
                        cnt_reg <= 16'(WE_HIGH_CYC - 1);
                        state_reg <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    if (cnt_reg != 16'h0000) begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end else if (idx_reg == last_idx) begin
                        flash_reg.ce_n <= 1'b1;
                        flash_reg.dq_oe <= 1'b0;
                        cnt_reg <= 16'(BUSY_VALID_CYC - 1);
                        state_reg <= (op_reg == OP_ABORT_RESET) ? S_IDLE : S_BUSY_WAIT;
                    end else begin
                        idx_reg <= idx_sel;
                        flash_reg.addr <= cyc.addr;
                        flash_reg.dq_out <= cyc.data;
                        cnt_reg <= 16'(SETUP_CYC - 1);
                        state_reg <= S_SETUP;
                    end
                end
                S_READ: begin
                    if (cnt_reg != 16'h0000) begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end else begin
                        rd_word_reg <= dq_in;
                        flash_reg.oe_n <= 1'b1;
                        flash_reg.ce_n <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                S_BUSY_WAIT: begin
                    // wait for busy pin release; no commands meanwhile
                    if (cnt_reg != 16'h0000) begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end else if (busy_indicator_n) begin
                        state_reg <= S_IDLE;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_we_under_ce;
        !flash_reg.we_n |-> !flash_reg.ce_n && flash_reg.dq_oe;
    endproperty
    a_we_under_ce: assert property (p_we_under_ce) else $error("write strobe without select");

    property p_we_width;
        $fell(flash_reg.we_n) |-> !flash_reg.we_n [*8] ##1 flash_reg.we_n && !flash_reg.ce_n;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

    property p_wp_steady;
        state_reg != S_IDLE |-> $stable(flash_reg.wp_n);
    endproperty
    a_wp_steady: assert property (p_wp_steady) else $error("protect level moved in sequence");

    property p_buf_count;
        state_reg != S_IDLE && op_reg == OP_BUFFER |-> nwords_reg >= 5'h01 && nwords_reg <= 5'h10;
    endproperty
    a_buf_count: assert property (p_buf_count) else $error("buffer word count out of range");

    property p_abort_code;
        $fell(flash_reg.we_n) && op_reg == OP_ABORT_RESET && idx_reg == 5'h02
            |-> flash_reg.dq_out == CODE_ABORT_RESET ##[1:20] state_reg == S_IDLE;
    endproperty
    a_abort_code: assert property (p_abort_code) else $error("abort reset cycle wrong");

    c_program: cover property (state_reg == S_BUSY_WAIT && op_reg == OP_PROGRAM && busy_indicator_n);
    c_buffer: cover property ($rose(flash_reg.we_n) && op_reg == OP_BUFFER && idx_reg == 5'h14);
    c_erase: cover property (state_reg == S_BUSY_WAIT && op_reg == OP_ERASE);
    c_read: cover property (state_reg == S_READ ##1 state_reg == S_IDLE);

endmodule : flash_host_ctrl

/* File: flash_model.sv */
// Behavioural parallel NOR flash standing on the controller's far side
module flash_model
    import flash_host_pkg::*;
#(
    parameter int PROG_NS = 7000,
    parameter int ERASE_NS = 2000
) (
    input wire logic clk,
    input wire flash_out_t pins,
    output logic [15:0] dq,
    output logic busy_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [logic [21:0]];
    bus_cycle_t log_q [$];
    logic [21:0] a_lat;
    logic [15:0] prev = 16'h0000;
    logic [15:0] d, p;
    logic [15:0] junk = 16'h0F0F;
    logic busy = 1'b0;

    // Unwritten words read as erased
    function automatic logic [15:0] rd(input logic [21:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction : rd

    task automatic run(input int ns);
        busy = 1'b1;
        #(ns);
        busy = 1'b0;
    endtask : run

    // Released bus shows a changing pattern, never a stale value
    always @(posedge clk) junk <= ~junk;
    // any address reads at once unless busy, when dq shows only ~prev[7] on bit 7; gating
    always @* begin
        if (pins.ce_n || pins.oe_n) dq = junk;
        else if (busy) dq = {8'h00, ~prev[7], 7'h00};
        else dq = rd(pins.addr);
    end
    assign busy_n = busy ? 1'b0 : 1'b1;
    always @(negedge pins.we_n) if (!pins.ce_n) a_lat = pins.addr;
    always @(posedge pins.we_n) if (!pins.ce_n && !busy) begin
        d = pins.dq_out;
        p = prev;
        prev = d;
        log_q.push_back({a_lat, d});
        if (p == CODE_PROGRAM) begin
            mem[a_lat] = rd(a_lat) & d;
            run(PROG_NS);
        end
        else if (d == CODE_BLOCK_ERASE && p == CODE_UNLOCK2 && pins.wp_n) begin
            foreach (mem[k]) if (k[21:15] == a_lat[21:15]) mem[k] = 16'hFFFF;
            run(ERASE_NS);
        end
        else if (d == CODE_BUF_COMMIT) run(PROG_NS);
    end
endmodule : flash_model

/* File: tb_flash_host_ctrl.sv */
// Self-checking bench for the AXI4-Lite NOR flash host controller
module tb_flash_host_ctrl;
    import flash_host_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [21:0] PA = 22'h01_2345;
    localparam logic [21:0] BA = 22'h02_0010;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, busy_n;
    logic [31:0] rdata;
    logic [1:0] bresp, rresp;
    logic [15:0] dq;
    flash_out_t fo;
    int failures = 0, total_checks = 0, base = 0;

    always #2.5 aclk = ~aclk;

    flash_host_ctrl i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .flash_o(fo), .dq_in(dq), .busy_indicator_n(busy_n));
    flash_model i_flash (.clk(aclk), .pins(fo), .dq(dq), .busy_n(busy_n));

    task automatic check(input logic [37:0] got, input logic [37:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Master holds each channel until its own handshake edge
    // No cycle limit here: only the watchdog ends a hung wait
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        check({36'h0, bresp}, {36'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check({4'h0, r, d}, {4'h0, er, ed});
    endtask : rd_chk

    // Start one operation and poll until the sequencer is idle again
    task automatic op(input op_t code);
        logic [31:0] s;
        logic [1:0] r;
        base = i_flash.log_q.size();
        wr(CMD_OFF, 32'h0000_0100 | 32'(code), RESP_OKAY);
        do begin
            rd(STATUS_OFF, s, r);
        end while (s[ST_BUSY_BIT] !== 1'b0);
    endtask : op

    task automatic cyc(input int i, input logic [21:0] a, input logic [15:0] d);
        check(i_flash.log_q[base + i], {a, d});
    endtask : cyc

    task automatic read_word(input logic [21:0] a, input logic [15:0] exp);
        wr(ADDR_OFF, {10'h000, a}, RESP_OKAY);
        op(OP_READ);
        rd_chk(RDATA_OFF, RESP_OKAY, {16'h0000, exp});
    endtask : read_word

    task automatic t_reset;
        rd_chk(COUNT_OFF, RESP_OKAY, 32'h0000_0001);
        rd_chk(WP_OFF, RESP_OKAY, 32'h0000_0001);
        rd_chk(8'h30, RESP_SLVERR, 32'h0000_0000);
        wr(8'h34, 32'h0000_0000, RESP_SLVERR);
        $display("test reset done");
    endtask : t_reset

    task automatic t_program;
        wr(WDATA_OFF, 32'h0000_A5C3, RESP_OKAY);
        wr(ADDR_OFF, {10'h000, PA}, RESP_OKAY);
        op(OP_PROGRAM);
        check(38'(i_flash.log_q.size() - base), 38'd4);
        cyc(0, ADDR_UNLOCK1, CODE_UNLOCK1);
        cyc(2, ADDR_UNLOCK1, CODE_PROGRAM);
        cyc(3, PA, 16'hA5C3);
        read_word(PA, 16'hA5C3);
        $display("test program done");
    endtask : t_program

    task automatic t_erase;
        wr(WP_OFF, 32'h0000_0000, RESP_OKAY);
        op(OP_ERASE);
        read_word(PA, 16'hA5C3);
        wr(WP_OFF, 32'h0000_0001, RESP_OKAY);
        op(OP_ERASE);
        cyc(5, {PA[21:15], 15'h0000}, CODE_BLOCK_ERASE);
        read_word(PA, 16'hFFFF);
        $display("test erase done");
    endtask : t_erase

    task automatic t_buffer;
        wr(COUNT_OFF, 32'h0000_0003, RESP_OKAY);
        for (int i = 0; i < 3; i++) wr(8'(8'h40 + 4 * i), 32'h0000_1230 + i, RESP_OKAY);
        wr(ADDR_OFF, {10'h000, BA}, RESP_OKAY);
        op(OP_BUFFER);
        check(38'(i_flash.log_q.size() - base), 38'd8);
        check({22'h0, i_flash.log_q[base + 3].data}, 38'h2);
        for (int i = 0; i < 3; i++) cyc(4 + i, {BA[21:4], 4'(i)}, 16'h1230 + 16'(i));
        check({22'h0, i_flash.log_q[base + 7].data}, 38'(CODE_BUF_COMMIT));
        rd_chk(8'h44, RESP_OKAY, 32'h0000_1231);
        op(OP_ABORT_RESET);
        check(38'(i_flash.log_q.size() - base), 38'd3);
        cyc(2, ADDR_UNLOCK1, CODE_ABORT_RESET);
        $display("test buffer done");
    endtask : t_buffer

    // A zero word count is refused before any bus cycle
    task automatic t_refuse;
        wr(COUNT_OFF, 32'h0000_0000, RESP_OKAY);
        op(OP_BUFFER);
        check(38'(i_flash.log_q.size() - base), 38'd0);
        rd_chk(STATUS_OFF, RESP_OKAY, 32'h0000_0006);
        wr(STATUS_OFF, 32'h0000_0002, RESP_OKAY);
        rd_chk(STATUS_OFF, RESP_OKAY, 32'h0000_0004);
        rd_chk(CMD_OFF, RESP_OKAY, 32'(OP_ABORT_RESET));
        $display("test refuse done");
    endtask : t_refuse

    task automatic conclude;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // Whole run should take about 20 us
    initial begin
        #400us;
        failures++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_program();
        t_erase();
        t_buffer();
        t_refuse();
        conclude();
    end
endmodule : tb_flash_host_ctrl
